// ---- bmf_regs.vh ----
// Constants for the bus-matching bidirectional FIFO block.
`ifndef BMF_REGS_VH
`define BMF_REGS_VH
`define BMF_CTRL_ADDR	12'h000
`define BMF_STAT_ADDR	12'h004
`define BMF_LVL_ADDR	12'h008
`define BMF_CTRL_RST	2'h0
`define BMF_W36		2'h0
`define BMF_W18		2'h1
`define BMF_W9		2'h2
`define BMF_SH18	6'h12
`define BMF_M36		36'hf_ffff_ffff
`define BMF_M18		36'h0_0003_ffff
`define BMF_M9		36'h0_0000_01ff
`define BMF_FS_SER	3'h0
`define BMF_FS_8	3'h1
`define BMF_FS_16	3'h2
`define BMF_FS_64	3'h3
`define BMF_FS_256	3'h4
`define BMF_FS_1K	3'h5
`define BMF_OFF_8	16'h0008
`define BMF_OFF_16	16'h0010
`define BMF_OFF_64	16'h0040
`define BMF_OFF_256	16'h0100
`define BMF_OFF_1K	16'h0400
`define BMF_PAR_LOADS	8'h04
`define BMF_ST_EVA	0
`define BMF_ST_EVB	1
`define BMF_ST_FSA	2
`define BMF_ST_FSB	3
`define BMF_ST_MF1	4
`define BMF_ST_MF2	5
`define BMF_ST_PGM	6
`define BMF_ST_PD	7
`define BMF_ST_BIG	8
`endif

// ---- bmf_top.v ----
// Bus-matching bidirectional FIFO pair with mailboxes and APB control.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "bmf_regs.vh"

// One direction of transfer with width matching on both sides.
module bmf_chan #(
	parameter AW = 14
) (
	input	wire		clk,
	input	wire		nrst,
	input	wire		mrst,
	input	wire		flush,
	input	wire		retx,
	input	wire		fall_through_mode,
	input	wire		big,
	input	wire [1:0]	wr_w,
	input	wire [1:0]	rd_w,
	input	wire		wclk_e,
	input	wire		rclk_e,
	input	wire		we,
	input	wire [35:0]	din,
	input	wire		re,
	input	wire [AW-1:0]	x_off,
	input	wire [AW-1:0]	y_off,
	output	reg [35:0]	dout,
	output	wire [AW:0]	cnt,
	output	wire		ev,
	output	wire		fs,
	output	wire		ae_n,
	output	wire		af_n
);
	localparam [AW:0] DP = {1'b1, {AW{1'b0}}};
	localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};

	function [2:0] npc;
		input [1:0] w;
		npc = (w == `BMF_W18) ? 3'h2 : (w == `BMF_W9) ? 3'h4 : 3'h1;
	endfunction

	function [35:0] pmask;
		input [1:0] w;
		pmask = (w == `BMF_W18) ? `BMF_M18 :
			(w == `BMF_W9) ? `BMF_M9 : `BMF_M36;
	endfunction

	// Bit position of transfer k within a long word.
	function [5:0] psh;
		input [1:0] w;
		input [1:0] k;
		input b;
		reg [2:0] n;
		reg [1:0] p;
		begin
			n = npc(w);
			p = b ? (n[1:0] - 2'h1 - k) : k;
			psh = (w == `BMF_W18) ? (p[0] ? `BMF_SH18 : 6'h00) :
				(w == `BMF_W9) ? ({1'b0, p, 3'h0} + {4'h0, p}) :
				6'h00;
		end
	endfunction

	function [35:0] pget;
		input [35:0] word;
		input [1:0] w;
		input [1:0] k;
		input b;
		pget = (word >> psh(w, k, b)) & pmask(w);
	endfunction

	reg [35:0]	mem [0:(1<<AW)-1];
	reg [AW:0]	wp_q;
	reg [AW:0]	rp_q;
	reg [1:0]	wl_q;
	reg [1:0]	rl_q;
	reg [35:0]	wh_q;
	reg [35:0]	rh_q;
	reg		rv_q;
	reg [1:0]	evs_q;
	reg [1:0]	fss_q;
	reg [1:0]	aes_q;
	reg [1:0]	afs_q;

	wire		full = (cnt == DP);
	wire		empty = (cnt == {(AW+1){1'b0}});
	wire [5:0]	wsh = psh(wr_w, wl_q, big);
	wire [35:0]	wword = (wh_q & ~(pmask(wr_w) << wsh)) |
			((din & pmask(wr_w)) << wsh);
	wire		wlast = ({1'b0, wl_q} == npc(wr_w) - 3'h1);
	wire		rlast = ({1'b0, rl_q} == npc(rd_w) - 3'h1);
	wire		wacc = we & ~full & ~mrst & ~flush;
	wire [35:0]	mrd = mem[rp_q[AW-1:0]];

	assign cnt = wp_q - rp_q;
	assign ev = evs_q[1];
	assign fs = fss_q[1];
	assign ae_n = aes_q[1];
	assign af_n = afs_q[1];

	// Narrow writes gather into a long word before it is stored.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= {(AW+1){1'b0}};
			wl_q <= 2'h0;
			wh_q <= 36'h0;
		end else if (mrst | flush) begin
			wp_q <= {(AW+1){1'b0}};
			wl_q <= 2'h0;
		end else if (wacc) begin
			wh_q <= wword;
			if (wlast) begin
				wp_q <= wp_q + ONE;
				wl_q <= 2'h0;
			end else begin
				wl_q <= wl_q + 2'h1;
			end
		end
	end

	always @(posedge clk) begin
		if (wacc & wlast) begin
			mem[wp_q[AW-1:0]] <= wword;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rp_q <= {(AW+1){1'b0}};
			rl_q <= 2'h0;
			rh_q <= 36'h0;
			rv_q <= 1'b0;
			dout <= 36'h0;
		end else if (mrst | flush | retx) begin
			rp_q <= {(AW+1){1'b0}};
			rl_q <= 2'h0;
			rv_q <= 1'b0;
		end else if (!fall_through_mode) begin
			if (re & (rl_q != 2'h0)) begin
				dout <= pget(rh_q, rd_w, rl_q, big);
				rl_q <= rlast ? 2'h0 : rl_q + 2'h1;
			end else if (re & ~empty) begin
				rh_q <= mrd;
				rp_q <= rp_q + ONE;
				dout <= pget(mrd, rd_w, 2'h0, big);
				rl_q <= rlast ? 2'h0 : rl_q + 2'h1;
			end
		end else if (rv_q & re & ~rlast) begin
			dout <= pget(rh_q, rd_w, rl_q + 2'h1, big);
			rl_q <= rl_q + 2'h1;
		end else if (~rv_q | (re & rlast)) begin
			rl_q <= 2'h0;
			if (!empty) begin
				rh_q <= mrd;
				rp_q <= rp_q + ONE;
				rv_q <= 1'b1;
				dout <= pget(mrd, rd_w, 2'h0, big);
			end else begin
				rv_q <= 1'b0;
			end
		end
	end

	// Write-side flags follow the writer's clock, read-side the reader's.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fss_q <= 2'h0;
			afs_q <= 2'h0;
			evs_q <= 2'h0;
			aes_q <= 2'h0;
		end else begin
			if (wclk_e) begin
				fss_q <= {fss_q[0], ~full};
				afs_q <= {afs_q[0], (DP - cnt) > {1'b0, y_off}};
			end
			if (rclk_e) begin
				evs_q <= {evs_q[0],
					fall_through_mode ? rv_q : (~empty | (rl_q != 2'h0))};
				aes_q <= {aes_q[0], cnt > {1'b0, x_off}};
			end
		end
	end
endmodule // bmf_chan

// Functional notes
// - Two 36-bit FIFOs, A to B and B to A.
// - Port B is 36, 18 or 9 bits, either endian.
// - Transfers on port clock rise when enabled.
// - Port clocks independent; same-edge read and write work.
// - Two mailboxes bypass FIFOs, port B width.
// - Each mailbox raises a new-mail flag.
// - Master reset clears pointers, latches endian, offsets method.
// - Two master reset inputs.
// - Partial reset flushes, keeps configuration and offsets.
// - Each FIFO has its own partial reset.
// - Retransmit rewinds only the read pointer.
// - Replay select turns partial reset pin into retransmit.
// - Standard mode needs a read for every word.
// - Fall-through shows first word without a read.
// - Fall-through select level picks the mode.
// - Combined empty/valid and full/space flags.
// - Programmable almost-empty and almost-full flags.
// - Flags synchronised twice to owning port clock.
// - Offsets load in parallel on port A or serially.
// - Offset selects at master reset choose defaults.
// - Interspersed parity skips data line 8 when loading.
// - Idle indication, left at once on any activity.
// - Port A almost-empty low when B-to-A count low.
// - Port A almost-full low when A-to-B space low.
module bmf_top #(
	parameter AW = 14
) (
	input	wire		clk,
	input	wire		nrst,
	input	wire		psel,
	input	wire		penable,
	input	wire		pwrite,
	input	wire [11:0]	paddr,
	input	wire [31:0]	pwdata,
	output	wire [31:0]	prdata,
	output	wire		pready,
	output	wire		pslverr,
	input	wire		clock_a_side,
	input	wire		a_sel,
	input	wire		a_write,
	input	wire		a_en,
	input	wire		a_mbox,
	input	wire [35:0]	a_din,
	output	wire [35:0]	a_dout,
	output	wire		a_doe,
	input	wire		clock_b_side,
	input	wire		b_sel,
	input	wire		b_write,
	input	wire		b_en,
	input	wire		b_mbox,
	input	wire [35:0]	b_din,
	output	wire [35:0]	b_dout,
	output	wire		b_doe,
	input	wire		full_reset_1_n,
	input	wire		full_reset_2_n,
	input	wire		flush_reset_1_n,
	input	wire		flush_reset_2_n,
	input	wire		replay_mode_select,
	input	wire		endian_or_fallthrough_select,
	input	wire		offset_select_0,
	input	wire		offset_select_1,
	input	wire		offset_select_2,
	input	wire		parity_select,
	input	wire		serial_load_en,
	input	wire		serial_offset_in,
	output	wire		empty_valid_a_side,
	output	wire		empty_valid_b_side,
	output	wire		full_space_a_side,
	output	wire		full_space_b_side,
	output	wire		almost_empty_a_side_n,
	output	wire		almost_empty_b_side_n,
	output	wire		almost_full_a_side_n,
	output	wire		almost_full_b_side_n,
	output	wire		mail_flag_1,
	output	wire		mail_flag_2,
	output	wire		power_down
);
	localparam [7:0] NSER = 4 * AW;

	function [35:0] pmask;
		input [1:0] w;
		pmask = (w == `BMF_W18) ? `BMF_M18 :
			(w == `BMF_W9) ? `BMF_M9 : `BMF_M36;
	endfunction

	function [AW-1:0] dflt;
		input [2:0] s;
		reg [15:0] v;
		begin
			case (s)
				`BMF_FS_8: v = `BMF_OFF_8;
				`BMF_FS_16: v = `BMF_OFF_16;
				`BMF_FS_64: v = `BMF_OFF_64;
				`BMF_FS_256: v = `BMF_OFF_256;
				`BMF_FS_1K: v = `BMF_OFF_1K;
				default: v = 16'h0000;
			endcase
			dflt = v[AW-1:0];
		end
	endfunction

	reg		ca_q;
	reg		cb_q;
	reg [1:0]	bw_q;
	reg		big_q;
	reg [2:0]	fsel_q;
	reg		par_q;
	reg [7:0]	pl_q;
	reg [4*AW-1:0]	offs_q;
	reg [35:0]	mb1_q;
	reg [35:0]	mb2_q;
	reg		mf1_q;
	reg		mf2_q;
	reg [35:0]	am_q;
	reg [35:0]	bm_q;
	reg		asm_q;
	reg		bsm_q;
	reg		pd_q;
	reg [31:0]	prd_q;

	// Port clocks are sampled; a rising edge becomes a one-cycle enable.
	wire		ea = clock_a_side & ~ca_q;
	wire		eb = clock_b_side & ~cb_q;
	wire		aq = ea & a_sel & a_en;
	wire		bq = eb & b_sel & b_en;
	wire		pdone = (pl_q == 8'h00);
	wire		ser = (fsel_q == `BMF_FS_SER);
	wire		wa = aq & a_write & ~a_mbox & pdone;
	wire		ra = aq & ~a_write & ~a_mbox;
	wire		wb = bq & b_write & ~b_mbox;
	wire		rb = bq & ~b_write & ~b_mbox;
	wire		mra = ~full_reset_1_n | ~full_reset_2_n;
	wire		fall_through_mode = endian_or_fallthrough_select;
	wire [2:0]	fsin = {offset_select_2, offset_select_1,
			offset_select_0};
	wire [AW-1:0]	pval = par_q ? {a_din[AW:9], a_din[7:0]}
			: a_din[AW-1:0];
	wire [AW:0]	c1;
	wire [AW:0]	c2;
	wire [35:0]	d1;
	wire [35:0]	d2;
	wire		acc = psel & penable;
	wire		hit = (paddr == `BMF_CTRL_ADDR) |
			(paddr == `BMF_STAT_ADDR) | (paddr == `BMF_LVL_ADDR);
	wire [31:0]	st = {23'h0, big_q, pd_q, pdone, mf2_q, mf1_q,
			full_space_b_side, full_space_a_side,
			empty_valid_b_side, empty_valid_a_side};

	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = prd_q;
	assign a_doe = a_sel & ~a_write;
	assign b_doe = b_sel & ~b_write;
	assign a_dout = asm_q ? am_q : d2;
	assign b_dout = bsm_q ? bm_q : d1;
	assign mail_flag_1 = mf1_q;
	assign mail_flag_2 = mf2_q;
	assign power_down = pd_q;

	// Setup, defaults and offset loading; master reset is a sampled level.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ca_q <= 1'b0;
			cb_q <= 1'b0;
			big_q <= 1'b0;
			fsel_q <= `BMF_FS_8;
			par_q <= 1'b0;
			pl_q <= 8'h00;
			offs_q <= {4{dflt(`BMF_FS_8)}};
		end else begin
			ca_q <= clock_a_side;
			cb_q <= clock_b_side;
			if (mra) begin
				big_q <= endian_or_fallthrough_select;
				fsel_q <= fsin;
				par_q <= parity_select;
				offs_q <= {4{dflt(fsin)}};
				pl_q <= (fsin == `BMF_FS_SER) ? NSER :
					(dflt(fsin) == {AW{1'b0}}) ?
					`BMF_PAR_LOADS : 8'h00;
			end else if (!pdone & ser & ea & serial_load_en) begin
				offs_q <= {offs_q[4*AW-2:0],
					serial_offset_in};
				pl_q <= pl_q - 8'h01;
			end else if (!pdone & !ser & aq & a_write & ~a_mbox) begin
				offs_q <= {offs_q[3*AW-1:0], pval};
				pl_q <= pl_q - 8'h01;
			end
		end
	end

	// Mailboxes: a new write raises the flag even during the clearing read.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mb1_q <= 36'h0;
			mb2_q <= 36'h0;
			mf1_q <= 1'b0;
			mf2_q <= 1'b0;
			am_q <= 36'h0;
			bm_q <= 36'h0;
			asm_q <= 1'b0;
			bsm_q <= 1'b0;
		end else if (mra) begin
			mf1_q <= 1'b0;
			mf2_q <= 1'b0;
		end else begin
			if (aq & a_write & a_mbox) begin
				mb1_q <= a_din & pmask(bw_q);
				mf1_q <= 1'b1;
			end else if (bq & ~b_write & b_mbox) begin
				mf1_q <= 1'b0;
			end
			if (bq & b_write & b_mbox) begin
				mb2_q <= b_din & pmask(bw_q);
				mf2_q <= 1'b1;
			end else if (aq & ~a_write & a_mbox) begin
				mf2_q <= 1'b0;
			end
			if (aq & ~a_write) begin
				asm_q <= a_mbox;
				if (a_mbox) begin
					am_q <= mb2_q;
				end
			end
			if (bq & ~b_write) begin
				bsm_q <= b_mbox;
				if (b_mbox) begin
					bm_q <= mb1_q;
				end
			end
		end
	end

	// Idle shows while nothing is selected; any active control clears it.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pd_q <= 1'b0;
		end else begin
			pd_q <= ~(a_sel | b_sel | psel | serial_load_en | mra |
				~flush_reset_1_n | ~flush_reset_2_n);
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bw_q <= `BMF_CTRL_RST;
			prd_q <= 32'h0;
		end else begin
			if (acc & pwrite & (paddr == `BMF_CTRL_ADDR)) begin
				bw_q <= pwdata[1:0];
			end
			if (psel & ~penable & ~pwrite) begin
				case (paddr)
					`BMF_CTRL_ADDR: prd_q <= {30'h0, bw_q};
					`BMF_STAT_ADDR: prd_q <= st;
					`BMF_LVL_ADDR: prd_q <=
						{{(15-AW){1'b0}}, c2,
						{(15-AW){1'b0}}, c1};
					default: prd_q <= 32'h0;
				endcase
			end
		end
	end

	bmf_chan #(.AW(AW)) u_ab (
		.clk	(clk),
		.nrst	(nrst),
		.mrst	(~full_reset_1_n),
		.flush	(~flush_reset_1_n & ~replay_mode_select),
		.retx	(~flush_reset_1_n & replay_mode_select),
		.fall_through_mode	(fall_through_mode),
		.big	(big_q),
		.wr_w	(`BMF_W36),
		.rd_w	(bw_q),
		.wclk_e	(ea),
		.rclk_e	(eb),
		.we	(wa),
		.din	(a_din),
		.re	(rb),
		.x_off	(offs_q[4*AW-1:3*AW]),
		.y_off	(offs_q[3*AW-1:2*AW]),
		.dout	(d1),
		.cnt	(c1),
		.ev	(empty_valid_b_side),
		.fs	(full_space_a_side),
		.ae_n	(almost_empty_b_side_n),
		.af_n	(almost_full_a_side_n)
	);

	bmf_chan #(.AW(AW)) u_ba (
		.clk	(clk),
		.nrst	(nrst),
		.mrst	(~full_reset_2_n),
		.flush	(~flush_reset_2_n & ~replay_mode_select),
		.retx	(~flush_reset_2_n & replay_mode_select),
		.fall_through_mode	(fall_through_mode),
		.big	(big_q),
		.wr_w	(bw_q),
		.rd_w	(`BMF_W36),
		.wclk_e	(eb),
		.rclk_e	(ea),
		.we	(wb),
		.din	(b_din),
		.re	(ra),
		.x_off	(offs_q[2*AW-1:AW]),
		.y_off	(offs_q[AW-1:0]),
		.dout	(d2),
		.cnt	(c2),
		.ev	(empty_valid_a_side),
		.fs	(full_space_b_side),
		.ae_n	(almost_empty_a_side_n),
		.af_n	(almost_full_b_side_n)
	);
endmodule // bmf_top

// ---- bmf_port_mdl.sv ----
// Port master model driving one side of the FIFO block.
`timescale 1ns/100ps
module bmf_port_mdl (
	input	wire		clk,
	output	wire		pclk,
	output	reg		sel = 1'b0,
	output	reg		en = 1'b0,
	output	reg		wr = 1'b0,
	output	reg		mb = 1'b0,
	output	reg [35:0]	din = 36'h0,
	input	wire [35:0]	dout
);
	reg [1:0]	ph_q = 2'h0;
	assign pclk = ph_q[1];
	always @(posedge clk) begin
		ph_q <= ph_q + 2'h1;
	end
	// Released data lines show the inverse so stale data never matches.
	task xfer(input logic w, input logic m, input logic [35:0] d,
		output logic [35:0] q);
		begin
			@(posedge clk);
			while (ph_q != 2'h0) @(posedge clk);
			sel <= 1'b1;
			en <= 1'b1;
			wr <= w;
			mb <= m;
			din <= d;
			while (ph_q != 2'h2) @(posedge clk);
			sel <= 1'b0;
			en <= 1'b0;
			din <= ~d;
			@(posedge clk);
			q = dout;
		end
	endtask
endmodule // bmf_port_mdl

// ---- bmf_top_props.sv ----
// Assertion checker for the bidirectional FIFO ports.
`timescale 1ns/100ps
module bmf_top_chk (
	input	wire	clk,
	input	wire	nrst,
	input	wire	clock_a_side,
	input	wire	clock_b_side,
	input	wire	a_sel,
	input	wire	a_en,
	input	wire	a_write,
	input	wire	a_mbox,
	input	wire	b_sel,
	input	wire	b_en,
	input	wire	b_write,
	input	wire	b_mbox,
	input	wire	full_reset_1_n,
	input	wire	flush_reset_1_n,
	input	wire	flush_reset_2_n,
	input	wire	replay_mode_select,
	input	wire	empty_valid_a_side,
	input	wire	empty_valid_b_side,
	input	wire	almost_empty_b_side_n,
	input	wire	mail_flag_1,
	input	wire	mail_flag_2,
	input	wire	power_down
);
	reg	ca_q;
	reg	cb_q;
	wire	ta = clock_a_side & ~ca_q & a_sel & a_en;
	wire	tb = clock_b_side & ~cb_q & b_sel & b_en;
	wire	wma = ta & a_write & a_mbox;
	wire	rma = ta & ~a_write & a_mbox;
	wire	wmb = tb & b_write & b_mbox;
	wire	rmb = tb & ~b_write & b_mbox;
	wire	f1 = ~flush_reset_1_n & ~replay_mode_select;
	wire	f2 = ~flush_reset_2_n & ~replay_mode_select;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ca_q <= 1'b0;
			cb_q <= 1'b0;
		end else begin
			ca_q <= clock_a_side;
			cb_q <= clock_b_side;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_mail_set_a: assert property (wma |=> mail_flag_1)
		else $error("mail flag 1 not set");
	a_mail_set_b: assert property (wmb |=> mail_flag_2)
		else $error("mail flag 2 not set");
	a_mail_clr_a: assert property (rmb && !wma |=> !mail_flag_1)
		else $error("mail flag 1 not cleared");
	a_mail_clr_b: assert property (rma && !wmb |=> !mail_flag_2)
		else $error("mail flag 2 not cleared");
	a_wake_up: assert property ($rose(a_sel) |-> ##[0:3] !power_down)
		else $error("idle state kept after select");
	a_flush_one: assert property (f1 [*8] |-> ##[0:20] !empty_valid_b_side)
		else $error("flush 1 left data");
	a_flush_two: assert property (f2 [*8] |-> ##[0:20] !empty_valid_a_side)
		else $error("flush 2 left data");
	a_flush_ae: assert property (f1 [*8] |-> ##[0:20] !almost_empty_b_side_n)
		else $error("almost empty not low after flush");
	a_mrst_clear: assert property (!full_reset_1_n [*4] |-> ##[0:20]
		!empty_valid_b_side)
		else $error("master reset left data");
	c_mail: cover property (wma);
	c_flush: cover property (f1 [*8]);
	c_wake: cover property ($fell(power_down));
endmodule // bmf_top_chk

bind bmf_top bmf_top_chk u_chk (.clk, .nrst, .clock_a_side, .clock_b_side,
	.a_sel, .a_en, .a_write, .a_mbox, .b_sel, .b_en, .b_write, .b_mbox,
	.full_reset_1_n, .flush_reset_1_n, .flush_reset_2_n, .replay_mode_select,
	.empty_valid_a_side, .empty_valid_b_side, .almost_empty_b_side_n,
	.mail_flag_1, .mail_flag_2, .power_down);

// ---- bmf_top_tb.sv ----
// Self-checking bench for the bus-matching bidirectional FIFO.
`timescale 1ns/100ps
module bmf_top_tb;
	reg		clk = 1'b0;
	reg		nrst = 1'b0;
	reg		psel = 1'b0;
	reg		penable = 1'b0;
	reg		pwrite = 1'b0;
	reg [11:0]	paddr = 12'h0;
	reg [31:0]	pwdata = 32'h0;
	reg		mr_n = 1'b1;
	reg		fl1_n = 1'b1;
	reg		fl2_n = 1'b1;
	reg		rm = 1'b0;
	reg		efs = 1'b0;
	reg [2:0]	fs = 3'h1;
	reg		se;
	reg [31:0]	r;
	reg [35:0]	q, v, p, m;
	integer		i, k, n, s;
	integer		cyc = 0;
	integer		bad_count = 0;
	integer		samples_checked = 0;
	wire [31:0]	prdata;
	wire		pready, pslverr, clock_a_side, clock_b_side;
	wire		a_sel, a_en, a_write, a_mbox, b_sel, b_en, b_write, b_mbox;
	wire [35:0]	a_din, a_dout, b_din, b_dout;
	wire		empty_valid_a_side, empty_valid_b_side, full_space_a_side;
	wire		almost_empty_b_side_n, almost_full_a_side_n;
	wire		full_space_b_side, almost_empty_a_side_n, almost_full_b_side_n;
	wire		mail_flag_1, mail_flag_2, power_down;
	bmf_top #(.AW(9)) dut (
		.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .clock_a_side, .a_sel, .a_write, .a_en, .a_mbox,
		.a_din, .a_dout, .a_doe(), .clock_b_side, .b_sel, .b_write, .b_en,
		.b_mbox, .b_din, .b_dout, .b_doe(), .full_reset_1_n(mr_n),
		.full_reset_2_n(mr_n), .flush_reset_1_n(fl1_n),
		.flush_reset_2_n(fl2_n), .replay_mode_select(rm),
		.endian_or_fallthrough_select(efs), .offset_select_0(fs[0]),
		.offset_select_1(fs[1]), .offset_select_2(fs[2]),
		.parity_select(1'b0), .serial_load_en(1'b0), .serial_offset_in(1'b0),
		.empty_valid_a_side, .empty_valid_b_side, .full_space_a_side,
		.full_space_b_side, .almost_empty_a_side_n,
		.almost_empty_b_side_n, .almost_full_a_side_n,
		.almost_full_b_side_n, .mail_flag_1, .mail_flag_2, .power_down);
	bmf_port_mdl u_pa (.clk, .pclk(clock_a_side), .sel(a_sel), .en(a_en),
		.wr(a_write), .mb(a_mbox), .din(a_din), .dout(a_dout));
	bmf_port_mdl u_pb (.clk, .pclk(clock_b_side), .sel(b_sel), .en(b_en),
		.wr(b_write), .mb(b_mbox), .din(b_din), .dout(b_dout));
	initial begin
		forever #5 clk = ~clk;
	end
	task chk(input logic [35:0] a, input logic [35:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (a !== e) begin
				bad_count = bad_count + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, a, e);
			end
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1) @(posedge clk);
			r = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task aw(input logic [35:0] d);
		u_pa.xfer(1'b1, 1'b0, d, q);
	endtask
	task bw(input logic [35:0] d);
		u_pb.xfer(1'b1, 1'b0, d, q);
	endtask
	task ar;
		u_pa.xfer(1'b0, 1'b0, 36'h0, q);
	endtask
	task br;
		u_pb.xfer(1'b0, 1'b0, 36'h0, q);
	endtask
	task wt;
		repeat (24) @(posedge clk);
	endtask
	task tend(input integer t);
		$display("test %0d finished", t);
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			test_done;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		mr_n <= 1'b0;
		repeat (4) @(posedge clk);
		mr_n <= 1'b1;
		wt;
		for (i = 0; i < 8; i = i + 1)
			aw(36'ha_0000_0000 + i);
		wt;
		chk(empty_valid_b_side, 1'b1);
		chk(almost_empty_b_side_n, 1'b0);
		chk(b_dout, 36'h0);
		aw(36'ha_0000_0008);
		wt;
		chk(almost_empty_b_side_n, 1'b1);
		for (i = 0; i < 9; i = i + 1) begin
			br;
			chk(q, 36'ha_0000_0000 + i);
		end
		wt;
		chk(empty_valid_b_side, 1'b0);
		br;
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h0);
		tend(1);
		bw(36'h5_1111_2222);
		bw(36'h5_3333_4444);
		wt;
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h0002_0000);
		chk(almost_empty_a_side_n, 1'b0);
		chk(full_space_b_side, 1'b1);
		chk(almost_full_b_side_n, 1'b1);
		ar;
		chk(q, 36'h5_1111_2222);
		ar;
		chk(q, 36'h5_3333_4444);
		apb(1'b0, 12'h00c, 32'h0);
		chk(se, 1'b1);
		chk(r, 32'h0);
		tend(2);
		v = 36'h9_8765_4321;
		for (n = 1; n < 3; n = n + 1) begin
			s = (n == 1) ? 18 : 9;
			m = ~({36{1'b1}} << s);
			apb(1'b1, 12'h000, n);
			aw(v);
			wt;
			for (k = 0; k < 36 / s; k = k + 1) begin
				p = (v >> (s * k)) & m;
				br;
				chk(q, p);
				bw(p);
			end
			wt;
			ar;
			chk(q, v);
		end
		apb(1'b1, 12'h000, 32'h0);
		tend(3);
		u_pa.xfer(1'b1, 1'b1, v, q);
		wt;
		chk(mail_flag_1, 1'b1);
		u_pb.xfer(1'b0, 1'b1, 36'h0, q);
		chk(q, v);
		wt;
		chk(mail_flag_1, 1'b0);
		u_pb.xfer(1'b1, 1'b1, ~v, q);
		wt;
		chk(mail_flag_2, 1'b1);
		u_pa.xfer(1'b0, 1'b1, 36'h0, q);
		chk(q, ~v);
		tend(4);
		// Retransmit rewinds to location zero, so start from a flushed queue.
		fl1_n <= 1'b0;
		wt;
		fl1_n <= 1'b1;
		wt;
		aw(36'h3_0000_0001);
		aw(36'h3_0000_0002);
		wt;
		br;
		chk(q, 36'h3_0000_0001);
		rm <= 1'b1;
		fl1_n <= 1'b0;
		wt;
		fl1_n <= 1'b1;
		@(posedge clk);
		rm <= 1'b0;
		wt;
		br;
		chk(q, 36'h3_0000_0001);
		br;
		chk(q, 36'h3_0000_0002);
		aw(36'h3_0000_0003);
		bw(36'h4_0000_0004);
		wt;
		fl1_n <= 1'b0;
		wt;
		fl1_n <= 1'b1;
		wt;
		chk(empty_valid_b_side, 1'b0);
		chk(empty_valid_a_side, 1'b1);
		fl2_n <= 1'b0;
		wt;
		fl2_n <= 1'b1;
		wt;
		chk(empty_valid_a_side, 1'b0);
		tend(5);
		efs <= 1'b1;
		wt;
		aw(36'h6_0000_0006);
		wt;
		chk(empty_valid_b_side, 1'b1);
		chk(b_dout, 36'h6_0000_0006);
		br;
		wt;
		chk(empty_valid_b_side, 1'b0);
		efs <= 1'b0;
		tend(6);
		for (i = 0; i < 513; i = i + 1)
			aw(i);
		wt;
		chk(full_space_a_side, 1'b0);
		chk(almost_full_a_side_n, 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h0000_0200);
		br;
		chk(q, 36'h0);
		fl1_n <= 1'b0;
		wt;
		fl1_n <= 1'b1;
		wt;
		chk(power_down, 1'b1);
		tend(7);
		aw(36'h7_0000_0000);
		wt;
		chk(empty_valid_b_side, 1'b1);
		fs <= 3'h6;
		mr_n <= 1'b0;
		repeat (4) @(posedge clk);
		mr_n <= 1'b1;
		wt;
		chk(empty_valid_b_side, 1'b0);
		aw(36'h2);
		aw(36'h5);
		aw(36'h3);
		aw(36'h4);
		for (i = 1; i < 4; i = i + 1)
			aw(36'h7_0000_0000 + i);
		wt;
		apb(1'b0, 12'h004, 32'h0);
		chk(r[6], 1'b1);
		chk(almost_empty_b_side_n, 1'b1);
		br;
		chk(q, 36'h7_0000_0001);
		wt;
		chk(almost_empty_b_side_n, 1'b0);
		tend(8);
		test_done;
	end
endmodule // bmf_top_tb
